// ===== core/pmbus_margin_status_regs.sv
`timescale 1ns/1ps
module pmbus_margin_status_regs
  import pmbus_regs_pkg::*;
#(
  parameter int SLEW_CYC = SLEW_BASE_CYC
) (
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic reset, // Async reset, active high
  input wire logic cmd_valid, // Decoded command present, one cycle
  input wire logic cmd_write, // 1 write, 0 read
  input wire logic [7:0] cmd_code, // Command code
  input wire logic [15:0] cmd_wdata, // Write data word, low byte first on bus
  output logic rsp_valid, // Read data valid, one cycle
  output logic [15:0] rsp_rdata, // Read data word
  output logic rsp_error, // Command was refused
  input wire logic [STRAP_W-1:0] strap_margin_low, // Strapped low setpoint bits
  input wire logic [1:0] strap_slew_sel, // Strapped slew setting
  input wire logic [MANT_W-1:0] nominal_setpoint, // Setpoint outside margin low
  input wire logic vout_ov_fault, // Output overvoltage fault
  input wire logic vout_ov_warn, // Output overvoltage warning
  input wire logic vout_uv_warn, // Output undervoltage warning
  input wire logic output_undervoltage_fault, // Output undervoltage, output off
  input wire logic output_overcurrent_fault, // Output overcurrent fault
  input wire logic bias_supply_undervoltage_flag, // Bias supply undervoltage
  input wire logic input_lockout, // Input lockout, output off
  input wire logic overtemperature_fault, // Overtemperature, output off
  input wire logic temp_warn, // Temperature warning
  input wire logic mem_logic_fault, // Memory or logic fault
  input wire logic other_fault, // Fault not covered elsewhere
  input wire logic power_good_pin, // Power-good pin level
  output logic [MANT_W-1:0] vout_code, // Regulation target code
  output logic vout_settled, // Output at target
  output logic alert_n // Alert to host, active low
);
  // Host-visible register state
  logic [MANT_W-1:0] margin_low_r; // Low-margin setpoint mantissa
  logic [MANT_W-1:0] margin_low_nxt;
  logic [7:0] operation_r; // Operation state
  logic [7:0] operation_nxt;
  logic [1:0] slew_sel_r; // Captured slew strap
  logic [1:0] slew_sel_nxt;
  logic strap_done_r; // Straps captured after reset
  logic strap_done_nxt;

  // Read answer registers
  logic rsp_valid_r;
  logic rsp_valid_nxt;
  logic [15:0] rsp_rdata_r;
  logic [15:0] rsp_rdata_nxt;
  logic rsp_error_r;
  logic rsp_error_nxt;
  logic alert_n_r; // Registered alert pin
  logic alert_n_nxt;

  // Decode and status wiring
  logic wr_cmd; // Write this cycle
  logic rd_cmd; // Read this cycle
  logic clear_cmd; // Clear faults this cycle
  logic bad_cmd; // Unsupported access this cycle
  logic [STICKY_W-1:0] sticky_set; // Live conditions
  logic [STICKY_W-1:0] sticky; // Held flags
  logic commanded_on; // Operation on bit
  logic margin_low_sel; // Margin-low state chosen
  logic off_bit; // Live off indication
  logic [7:0] status_byte; // Fault summary byte
  logic [7:0] status_high; // Status word high byte
  logic [MANT_W-1:0] target_raw; // Selected setpoint
  logic [MANT_W-1:0] target; // Setpoint held in supported range
  logic slew_load; // Jump to setpoint at strap capture

  // Command decode
  assign wr_cmd = cmd_valid & cmd_write;
  assign rd_cmd = cmd_valid & ~cmd_write;
  assign clear_cmd = wr_cmd & (cmd_code == CMD_CLEAR_FAULTS);

  // Refuse codes this slice does not serve and writes to read-only codes
  always_comb
  begin
    bad_cmd = 1'b0;
    if (cmd_valid)
    begin
      case (cmd_code)
        CMD_OPERATION, CMD_MARGIN_LOW: bad_cmd = 1'b0;
        CMD_CLEAR_FAULTS: bad_cmd = ~cmd_write;
        CMD_VOUT_MODE, CMD_STATUS_BYTE, CMD_STATUS_WORD: bad_cmd = cmd_write;
        default: bad_cmd = 1'b1;
      endcase
    end
  end

  // Operation state decode
  assign commanded_on = operation_r[OP_ON_BIT];
  assign margin_low_sel = operation_r[OP_MARGIN_LSB+1:OP_MARGIN_LSB] == OP_MARGIN_LOW;

  // Next values of host-written registers and strap capture
  always_comb
  begin
    margin_low_nxt = margin_low_r;
    operation_nxt = operation_r;
    slew_sel_nxt = slew_sel_r;
    strap_done_nxt = 1'b1;
    if (!strap_done_r)
    begin
      // First cycle after reset: take pin straps
      margin_low_nxt = {2'h0, strap_margin_low};
      slew_sel_nxt = strap_slew_sel;
    end
    else if (wr_cmd)
    begin
      case (cmd_code)
        // Two-byte word, upper four bits read as zero
        CMD_MARGIN_LOW: margin_low_nxt = cmd_wdata[MANT_W-1:0];
        CMD_OPERATION: operation_nxt = cmd_wdata[7:0];
        default: margin_low_nxt = margin_low_r;
      endcase
    end
  end

  // Register host-written state
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      margin_low_r <= '0;
      operation_r <= OP_RESET;
      slew_sel_r <= 2'h0;
      strap_done_r <= 1'b0;
    end
    else
    begin
      margin_low_r <= margin_low_nxt;
      operation_r <= operation_nxt;
      slew_sel_r <= slew_sel_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  // Choose the target; margin-low uses the low setpoint
  assign target_raw = margin_low_sel ? margin_low_r : nominal_setpoint;

  // Hold the regulation target inside the supported mantissa range
  always_comb
  begin
    if (target_raw < MANT_MIN)
      target = MANT_MIN;
    else if (target_raw > MANT_MAX)
      target = MANT_MAX;
    else
      target = target_raw;
  end

  // Start regulation at the nominal setpoint, no ramp from zero
  assign slew_load = ~strap_done_r;

  // Output code steps toward target at strapped rate
  setpoint_slewer #(
    .W(MANT_W),
    .CW(SLEW_CNT_W)
  ) u_slewer (
    .clk_sys(clk_sys),
    .reset(reset),
    .base_cycles(SLEW_CNT_W'(SLEW_CYC)),
    .slew_sel(slew_sel_r),
    .load(slew_load),
    .target(target),
    .vout_code(vout_code),
    .settled(vout_settled)
  );

  // Live fault conditions feeding the held flags
  always_comb
  begin
    sticky_set = '0;
    sticky_set[SB_VOUT_OV] = vout_ov_fault;
    sticky_set[SB_IOUT_OC] = output_overcurrent_fault;
    sticky_set[SB_BIAS_UV] = bias_supply_undervoltage_flag;
    sticky_set[SB_TEMP] = overtemperature_fault | temp_warn;
    // Refused commands count as communication faults
    sticky_set[SB_CML] = mem_logic_fault | bad_cmd;
    sticky_set[SB_OTHER] = other_fault;
    // High byte flags sit above the six summary flags
    sticky_set[6] = vout_ov_fault | vout_ov_warn | vout_uv_warn
                    | output_undervoltage_fault;
    sticky_set[7] = output_overcurrent_fault;
    sticky_set[8] = bias_supply_undervoltage_flag;
  end

  // Held flags; a present condition wins over the clear
  sticky_flags #(
    .W(STICKY_W)
  ) u_flags (
    .clk_sys(clk_sys),
    .reset(reset),
    .set_in(sticky_set),
    .clear(clear_cmd),
    .flags(sticky)
  );

  // Off while commanded off or while undervoltage, overtemperature or input lockout holds the output off
  assign off_bit = ~commanded_on | output_undervoltage_fault
                   | overtemperature_fault | input_lockout;

  // Fault summary byte; bit 7 reads zero
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[SB_OFF] = off_bit;
    status_byte[5:0] = sticky[5:0];
  end

  // Status word high byte; unused bits read zero
  always_comb
  begin
    status_high = 8'h00;
    status_high[SW_VOUT] = sticky[6];
    status_high[SW_IOUT] = sticky[7];
    status_high[SW_VDD] = sticky[8];
    status_high[SW_PG_NEGATED] = ~power_good_pin;
  end

  // Read answer and alert next values
  always_comb
  begin
    rsp_valid_nxt = rd_cmd;
    rsp_rdata_nxt = rsp_rdata_r;
    rsp_error_nxt = bad_cmd;
    alert_n_nxt = ~(|sticky_set | |sticky);
    if (rd_cmd)
    begin
      case (cmd_code)
        CMD_OPERATION: rsp_rdata_nxt = {8'h00, operation_r};
        CMD_VOUT_MODE: rsp_rdata_nxt = {8'h00, VOUT_MODE_VALUE};
        CMD_MARGIN_LOW: rsp_rdata_nxt = {4'h0, margin_low_r};
        CMD_STATUS_BYTE: rsp_rdata_nxt = {8'h00, status_byte};
        CMD_STATUS_WORD: rsp_rdata_nxt = {status_high, status_byte};
        default: rsp_rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Register answers and alert pin
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= 16'h0000;
      rsp_error_r <= 1'b0;
      alert_n_r <= 1'b1;
    end
    else
    begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_rdata_r <= rsp_rdata_nxt;
      rsp_error_r <= rsp_error_nxt;
      alert_n_r <= alert_n_nxt;
    end
  end

  // Drive outputs from registers
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rsp_rdata_r;
  assign rsp_error = rsp_error_r;
  assign alert_n = alert_n_r;
endmodule

// ===== core/pmbus_regs_pkg.sv
package pmbus_regs_pkg;
  // Command codes seen on the management bus
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;

  // Output voltage mode: linear format, exponent -9
  localparam logic [7:0] VOUT_MODE_VALUE = 8'h17;

  // Margin setpoint mantissa layout
  localparam int MANT_W = 12;
  localparam int STRAP_W = 10;
  localparam logic [11:0] MANT_MIN = 12'h133;
  localparam logic [11:0] MANT_MAX = 12'h266;

  // Operation register fields and reset value
  localparam int OP_ON_BIT = 7;
  localparam int OP_MARGIN_LSB = 4;
  localparam logic [1:0] OP_MARGIN_LOW = 2'h1;
  localparam logic [7:0] OP_RESET = 8'h80;

  // Fault summary byte bit positions
  localparam int SB_OFF = 6;
  localparam int SB_VOUT_OV = 5;
  localparam int SB_IOUT_OC = 4;
  localparam int SB_BIAS_UV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_CML = 1;
  localparam int SB_OTHER = 0;

  // Status word high byte bit positions
  localparam int SW_VOUT = 7;
  localparam int SW_IOUT = 6;
  localparam int SW_VDD = 5;
  localparam int SW_PG_NEGATED = 3;

  // Number of sticky flags held (six summary plus three high byte)
  localparam int STICKY_W = 9;

  // Slew step timing at the base strap setting
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_SLEW_BASE_US = 4;
  localparam int SLEW_BASE_CYC = (T_SLEW_BASE_US * 1000000) / CLK_PERIOD_PS;
  localparam int SLEW_CNT_W = 16;
endpackage

// ===== core/setpoint_slewer.sv
`timescale 1ns/1ps
module setpoint_slewer #(
  parameter int W = 12,
  parameter int CW = 16
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic [CW-1:0] base_cycles, // Cycles per step at fastest strap
  input wire logic [1:0] slew_sel, // Strapped slew setting
  input wire logic load, // Jump straight to target
  input wire logic [W-1:0] target, // Wanted output code
  output logic [W-1:0] vout_code, // Present output code
  output logic settled // Output equals target
);
  logic [W-1:0] code_r; // Present output code
  logic [W-1:0] code_nxt;
  logic [CW+2:0] cnt_r; // Step timer
  logic [CW+2:0] cnt_nxt;
  logic [CW+2:0] period; // Cycles per step

  // Period doubles per strap step: 1x, 2x, 4x, 8x
  assign period = {3'h0, base_cycles} << slew_sel;

  // One code step each period toward the target
  always_comb
  begin
    code_nxt = code_r;
    cnt_nxt = cnt_r;
    if (load)
    begin
      code_nxt = target;
      cnt_nxt = '0;
    end
    else if (code_r == target)
      cnt_nxt = '0; // Idle, restart timer
    else if (cnt_r >= period - (CW+3)'(1))
    begin
      cnt_nxt = '0;
      if (code_r < target)
        code_nxt = code_r + W'(1);
      else
        code_nxt = code_r - W'(1);
    end
    else
      cnt_nxt = cnt_r + (CW+3)'(1);
  end

  // Register code and timer
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      code_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      code_r <= code_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign vout_code = code_r;
  assign settled = (code_r == target);
endmodule

// ===== core/sticky_flags.sv
`timescale 1ns/1ps
module sticky_flags #(
  parameter int W = 9
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic [W-1:0] set_in, // Live fault conditions
  input wire logic clear, // Clear all flags
  output logic [W-1:0] flags // Held flags
);
  logic [W-1:0] flags_r; // Held state
  logic [W-1:0] flags_nxt; // Next state

  // Per flag: a present condition beats the clear
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_flag
      always_comb
      begin
        if (set_in[i])
          flags_nxt[i] = 1'b1;
        else if (clear)
          flags_nxt[i] = 1'b0;
        else
          flags_nxt[i] = flags_r[i];
      end
    end
  endgenerate

  // Register all flags
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      flags_r <= '0;
    else
      flags_r <= flags_nxt;
  end

  assign flags = flags_r;
endmodule

// ===== dv/pmbus_host_model.sv
`timescale 1ns/1ps
// Management bus host: one command word out, its answer back
module pmbus_host_model (
  input wire logic clk_sys, // System clock
  input wire logic rsp_valid, // Read valid
  input wire logic [15:0] rsp_rdata, // Read data
  input wire logic rsp_error, // Refusal
  output logic cmd_valid, // Command strobe
  output logic cmd_write, // Write select
  output logic [7:0] cmd_code, // Command code
  output logic [15:0] cmd_wdata // Write word
);
  // Idle bus at time zero
  initial
  begin
    cmd_valid = 1'h0;
    cmd_write = 1'h0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // Hold the command over its taking edge, take the answer just after
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
    output logic [15:0] rd, output logic ok, output logic err);
    @(posedge clk_sys);
    cmd_valid <= 1'h1;
    cmd_write <= wr;
    cmd_code <= code;
    cmd_wdata <= wd;
    @(posedge clk_sys);
    cmd_valid <= 1'h0;
    // Released code and data lines show the inverse of the last value
    cmd_code <= ~code;
    cmd_wdata <= ~wd;
    #1;
    rd = rsp_rdata;
    ok = rsp_valid;
    err = rsp_error;
  endtask
endmodule

// ===== dv/pmbus_margin_status_chk.sv
`timescale 1ns/1ps
// Watches command answers, status bits, alert and output stepping
module pmbus_margin_status_chk
  import pmbus_regs_pkg::*;
#(
  parameter int SLEW_CYC = 800
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset
  input wire logic cmd_valid, // Command strobe
  input wire logic cmd_write, // Write select
  input wire logic [7:0] cmd_code, // Command code
  input wire logic rsp_valid, // Read valid
  input wire logic rsp_error, // Refusal
  input wire logic [15:0] rsp_rdata, // Read data
  input wire logic vout_ov_fault, // Overvoltage
  input wire logic output_overcurrent_fault, // Overcurrent
  input wire logic bias_supply_undervoltage_flag, // Bias undervoltage
  input wire logic overtemperature_fault, // Overtemperature
  input wire logic other_fault, // Other fault
  input wire logic power_good_pin, // Power-good level
  input wire logic [MANT_W-1:0] vout_code, // Output code
  input wire logic alert_n // Alert, active low
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Status reads of each register
  wire logic rd78 = cmd_valid && !cmd_write && cmd_code == CMD_STATUS_BYTE;
  wire logic rd79 = cmd_valid && !cmd_write && cmd_code == CMD_STATUS_WORD;
  a_read_answer: assert property (rd78 |=> rsp_valid && !rsp_error)
    else $error("status read not answered");
  a_off_temp: assert property (rd78 && overtemperature_fault &&
    $past(overtemperature_fault) && !$past(reset) |=> rsp_rdata[SB_OFF] && rsp_rdata[SB_TEMP])
    else $error("off or temperature bit missing");
  a_ov_flag: assert property (rd78 && $past(vout_ov_fault) && !$past(reset)
    |=> rsp_rdata[SB_VOUT_OV]) else $error("overvoltage bit missing");
  a_oc_flag: assert property (rd78 && $past(output_overcurrent_fault) && !$past(reset)
    |=> rsp_rdata[SB_IOUT_OC]) else $error("overcurrent bit missing");
  a_bias_flag: assert property (rd78 && $past(bias_supply_undervoltage_flag)
    && !$past(reset) |=> rsp_rdata[SB_BIAS_UV]) else $error("bias bit missing");
  a_power_good_negated_flag_mirror: assert property (rd79 |=>
    rsp_rdata[8+SW_PG_NEGATED] == !$past(power_good_pin)) else $error("power-good bit wrong");
  a_unused_zero: assert property (rd79 |=> rsp_rdata[12] == 1'h0 &&
    rsp_rdata[10:8] == 3'h0 && rsp_rdata[7] == 1'h0) else $error("unused bit set");
  a_alert_raise: assert property ($rose(other_fault) |-> ##[0:1] !alert_n)
    else $error("alert not raised");
  a_step_one: assert property (!$past(reset) && !$past(reset, 2) &&
    vout_code != $past(vout_code) |-> vout_code == $past(vout_code) + 12'h1 ||
    vout_code == $past(vout_code) - 12'h1) else $error("output jumped");
  a_slew_space: assert property (!$past(reset) && !$past(reset, 2) &&
    vout_code != $past(vout_code) |=> $stable(vout_code)[*3]) else $error("steps too close");
endmodule

bind pmbus_margin_status_regs pmbus_margin_status_chk #(.SLEW_CYC(SLEW_CYC)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
  .vout_ov_fault(vout_ov_fault), .output_overcurrent_fault(output_overcurrent_fault),
  .bias_supply_undervoltage_flag(bias_supply_undervoltage_flag),
  .overtemperature_fault(overtemperature_fault), .other_fault(other_fault),
  .power_good_pin(power_good_pin), .vout_code(vout_code), .alert_n(alert_n));

// ===== dv/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
// Status and margin bench
module testbench;
  import pmbus_regs_pkg::*;
  typedef struct packed {logic [3:0] idx; logic [7:0] live; logic [15:0] held;} row_t;
  logic clk_sys, reset, power_good_negated_flag, v, e;
  logic [1:0] slew_strap; // Strapped slew setting
  logic [10:0] flt; // Fault inputs, overvoltage first
  logic [15:0] d;
  wire logic rsp_valid, rsp_error, cmd_valid, cmd_write, vout_settled, alert_n;
  wire logic [15:0] rsp_rdata, cmd_wdata;
  wire logic [7:0] cmd_code;
  wire logic [11:0] vout_code;
  int n_fail = 0;
  int total_checks = 0;
  int n;
  // One fault each: summary while present, word after it went away
  row_t rows [11] = '{'{4'hA, 8'h20, 16'h8020}, '{4'h9, 8'h00, 16'h8000},
    '{4'h8, 8'h00, 16'h8000}, '{4'h7, 8'h40, 16'h8000}, '{4'h6, 8'h10, 16'h4010},
    '{4'h5, 8'h08, 16'h2008}, '{4'h4, 8'h40, 16'h0000}, '{4'h3, 8'h44, 16'h0004},
    '{4'h2, 8'h04, 16'h0004}, '{4'h1, 8'h02, 16'h0002}, '{4'h0, 8'h01, 16'h0001}};
  // 200 MHz clock
  initial
  begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  pmbus_host_model i_pmbus_host_model (.clk_sys(clk_sys), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  pmbus_margin_status_regs #(.SLEW_CYC(4)) i_pmbus_margin_status_regs (.clk_sys(clk_sys),
    .reset(reset), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_error(rsp_error), .strap_margin_low(10'h150), .strap_slew_sel(slew_strap),
    .nominal_setpoint(12'h200), .vout_ov_fault(flt[10]), .vout_ov_warn(flt[9]),
    .vout_uv_warn(flt[8]), .output_undervoltage_fault(flt[7]),
    .output_overcurrent_fault(flt[6]), .bias_supply_undervoltage_flag(flt[5]),
    .input_lockout(flt[4]), .overtemperature_fault(flt[3]), .temp_warn(flt[2]),
    .mem_logic_fault(flt[1]), .other_fault(flt[0]), .power_good_pin(power_good_negated_flag),
    .vout_code(vout_code), .vout_settled(vout_settled), .alert_n(alert_n));
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Read a word and compare it
  task automatic rd_chk(input logic [7:0] code, input logic [15:0] ex);
    i_pmbus_host_model.xfer(1'h0, code, 16'h0000, d, v, e);
    `CHK("read word", ex, d)
    `CHK("read valid", 1'h1, v)
  endtask
  // Write a word
  task automatic wr(input logic [7:0] code, input logic [15:0] wd);
    i_pmbus_host_model.xfer(1'h1, code, wd, d, v, e);
  endtask
  // Reset for 4 cycles, commands from the 2nd edge after release
  task automatic do_reset();
    @(posedge clk_sys) reset <= 1'h1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'h0;
    repeat (2) @(posedge clk_sys);
  endtask
  // Count cycles until the output reaches its target
  task automatic settle(output int cyc);
    @(posedge clk_sys);
    #1;
    for (cyc = 0; cyc < 2000 && vout_settled !== 1'h1; cyc++)
      @(posedge clk_sys) #1;
    if (cyc == 2000)
    begin
      n_fail++;
      conclude();
    end
  endtask
  // Main sequence
  initial
  begin
    reset = 1'h1;
    power_good_negated_flag = 1'h1;
    flt = 11'h000;
    slew_strap = 2'h0;
    do_reset();
    rd_chk(CMD_STATUS_WORD, 16'h0000);
    rd_chk(CMD_VOUT_MODE, 16'h0017);
    rd_chk(CMD_MARGIN_LOW, 16'h0150);
    `CHK("alert idle", 1'h1, alert_n)
    foreach (rows[i])
    begin
      @(posedge clk_sys) flt <= 11'h001 << rows[i].idx;
      repeat (2) @(posedge clk_sys);
      rd_chk(CMD_STATUS_BYTE, {8'h00, rows[i].live});
      // Input lockout only turns the output off; it raises no flag, so no alert
      `CHK("alert low", rows[i].held == 16'h0000, alert_n)
      @(posedge clk_sys) flt <= 11'h000;
      repeat (2) @(posedge clk_sys);
      rd_chk(CMD_STATUS_WORD, rows[i].held);
      wr(CMD_CLEAR_FAULTS, 16'h0000);
      rd_chk(CMD_STATUS_WORD, 16'h0000);
      `CHK("alert released", 1'h1, alert_n)
    end
    // Refused write raises the communication bit; unknown code is refused and reads zero
    wr(CMD_STATUS_BYTE, 16'h00FF);
    `CHK("refused", 1'h1, e)
    rd_chk(CMD_STATUS_BYTE, 16'h0002);
    i_pmbus_host_model.xfer(1'h0, 8'hFF, 16'h0000, d, v, e);
    `CHK("unknown code", 17'h10000, {e, d})
    // Fault still present across a clear
    @(posedge clk_sys) flt <= 11'h001;
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    rd_chk(CMD_STATUS_BYTE, 16'h0001);
    `CHK("alert again", 1'h0, alert_n)
    @(posedge clk_sys) flt <= 11'h000;
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    // Power-good pin low shows in the high byte
    @(posedge clk_sys) power_good_negated_flag <= 1'h0;
    rd_chk(CMD_STATUS_WORD, 16'h0800);
    @(posedge clk_sys) power_good_negated_flag <= 1'h1;
    // Margin low: 192 steps of 4 cycles
    wr(CMD_MARGIN_LOW, 16'h0140);
    wr(CMD_OPERATION, 16'h0090);
    settle(n);
    `CHK("slew time", 1'h1, n >= 745 && n <= 780)
    `CHK("margin out", 12'h140, vout_code)
    wr(CMD_MARGIN_LOW, 16'h0100);
    settle(n);
    `CHK("clamped out", 12'h133, vout_code)
    rd_chk(CMD_MARGIN_LOW, 16'h0100);
    wr(CMD_OPERATION, 16'h0080);
    settle(n);
    `CHK("nominal out", 12'h200, vout_code)
    // Second reset with a flag held and the slower slew strap
    @(posedge clk_sys) flt <= 11'h002;
    @(posedge clk_sys) flt <= 11'h000;
    slew_strap <= 2'h1;
    do_reset();
    rd_chk(CMD_STATUS_WORD, 16'h0000);
    rd_chk(CMD_MARGIN_LOW, 16'h0150);
    // Doubled step period: 176 steps of 8 cycles
    wr(CMD_OPERATION, 16'h0090);
    settle(n);
    `CHK("slow slew time", 1'h1, n >= 1390 && n <= 1420)
    `CHK("strap margin out", 12'h150, vout_code)
    conclude();
  end
endmodule
